// ==== pkg/flash_link_cfg.svh ====
// Constants shared by both ends of the serial register link: opcodes,
// field positions, reset values and link timing.
// Assumes it is included by its bare name before any module that uses it.
`ifndef FLASH_LINK_CFG_SVH
`define FLASH_LINK_CFG_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OPC_RD_BANK_A 8'h16
`define OPC_RD_BANK_B 8'hc8
`define OPC_WR_BANK_V_A 8'h17
`define OPC_WR_BANK_V_B 8'hc5
`define OPC_WR_BANK_NV 8'h18
`define OPC_ENTER_WIDE 8'hb7
`define OPC_EXIT_WIDE 8'h29
`define OPC_RD_PROT 8'h2b
`define OPC_PG_PROT 8'h2f
`define OPC_CLR_ERR 8'h8a
`define OPC_SW_RESET 8'h9a
`define OPC_RD_EXT 8'h8b
`define OPC_RD_BOOT 8'h14
`define OPC_WR_BOOT 8'h15
`define OPC_ARRAY_READ 8'h03

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define BANK_SEG_BIT 0
`define BANK_WIDE_BIT 7
`define BANK_RESET 8'h00
`define ASP_PARAM_LOC_BIT 15
`define ASP_RESET 16'hffff
`define BOOT_RESET 32'h00000000
`define BOOT_DLY_SINGLE 4'h8
`define BOOT_DLY_QUAD 4'h6
`define EXT_FIXED 8'hf0

// ----------------------------------------
// Host command port and link timing
// ----------------------------------------
`define HREG_CTRL 4'h0
`define HREG_TX 4'h4
`define HREG_RX 4'h8
`define HREG_STAT 4'hc
`define SCK_RISE_PH 3'h3
`define SCK_FALL_PH 3'h7

`endif

// ==== pkg/flash_link_pkg.sv ====
// Types shared by both ends of the serial register link.
// Assumes nothing beyond a SystemVerilog compiler.
package flash_link_pkg;

	typedef enum logic [3:0] {
		ST_IDLE, ST_OPCODE, ST_BANK_WR, ST_PROT_WR, ST_BOOT_WR,
		ST_ADDR, ST_DUMMY, ST_STREAM, ST_REG_OUT, ST_IGNORE
	} dev_state_t;

	typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} host_state_t;

endpackage : flash_link_pkg

// ==== pkg/spi_link_if.sv ====
// Four-wire serial link between the register host and the flash device.
// Assumes the bench instantiates it once and hands each end its modport.
`timescale 1ns/1ps
interface spi_link_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe;

	modport device (input sck, input cs_n, input mosi, output miso, output miso_oe);
	modport host (output sck, output cs_n, output mosi, input miso, input miso_oe);
endinterface : spi_link_if

// ==== design/flash_cfg_device.sv ====
// Flash device end: bank, auto-boot and advanced protection registers
// reached by opcodes on the serial link, plus sticky error flags.
// Assumes the link arrives asynchronously and the array sits on the user side.
//
// Behaviour
// - OTP and parameter-location zeros never revert; hardware reset here reloads the register with all ones
// - Read-only and frozen bits ignore writes silently
// - Error flags stay set until clear command
// - Hardware or software reset clears error flags
// - Commands still execute while error flags set
// - Boot bits 31:5 hold 32-byte start address
// - Boot bits 4:1 give initial delay cycles
// - Zero delay means 8, or 6 with quad
// - Boot bit 0 enables auto-boot, default zero
// - Bank read 16h/C8h, write 17h/C5h, 18h
// - B7h enters four-byte, 29h exits
// - Bank bit 0 selects upper 128Mb segment
// - Bank supplies high bits for three-byte addresses
// - Four-byte mode ignores bank, needs 32-bit address
// - Bank bit 7 selects address size
// - Bank 8 bits, 6:1 reserved, dual copies
// - Protection register read 2Bh, program 2Fh
// - Protection register 16 bits, all ones default
// - Extended status bit1 protection, bit2 program error
// - Programming both lock bits zero is error
// - Lock bit at zero fixes protection mode
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "flash_link_cfg.svh"

module flash_cfg_device (
	input wire logic core_clk_in,
	input wire logic rst_in,
	spi_link_if.device link,
	input wire logic quad_enable_bit_in,
	input wire logic freeze_lock_in,
	input wire logic prog_fail_in,
	input wire logic prot_fail_in,
	input wire logic [7:0] array_data_in,
	output logic [31:0] array_addr_out,
	output logic array_addr_valid_out,
	output logic four_byte_addr_sel_out,
	output logic protection_error_flag_out,
	output logic program_error_flag_out,
	output logic [15:0] advanced_protection_config_out
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [3:0] boot_delay(input logic [3:0] field, input logic quad);
		if (field == 4'h0) begin
			boot_delay = quad ? `BOOT_DLY_QUAD : `BOOT_DLY_SINGLE;
		end else begin
			boot_delay = field;
		end
	endfunction : boot_delay

	// ----------------------------------------
	// Link synchronisers
	// ----------------------------------------
	logic [1:0] sck_s_r;
	logic [1:0] cs_s_r;
	logic [1:0] mosi_s_r;
	logic sck_d_r;
	logic cs_d_r;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sck_s_r <= 2'h0;
			cs_s_r <= 2'h3;
			mosi_s_r <= 2'h0;
			sck_d_r <= 1'b0;
			cs_d_r <= 1'b1;
		end else begin
			sck_s_r <= {sck_s_r[0], link.sck};
			cs_s_r <= {cs_s_r[0], link.cs_n};
			mosi_s_r <= {mosi_s_r[0], link.mosi};
			sck_d_r <= sck_s_r[1];
			cs_d_r <= cs_s_r[1];
		end
	end

	wire sel = ~cs_s_r[1];
	wire sck_rise = sel & sck_s_r[1] & ~sck_d_r;
	wire sck_fall = sel & ~sck_s_r[1] & sck_d_r;
	wire cs_fall = ~cs_s_r[1] & cs_d_r;

	// ----------------------------------------
	// State and registers
	// ----------------------------------------
	flash_link_pkg::dev_state_t state_r;
	flash_link_pkg::dev_state_t state_nxt;
	flash_link_pkg::dev_state_t opc_state;
	logic [7:0] in_sr_r;
	logic [2:0] bit_cnt_r;
	logic [2:0] byte_cnt_r;
	logic [31:0] acc_r;
	logic [31:0] out_sr_r;
	logic hold_r;
	logic [2:0] out_cnt_r;
	logic [3:0] dly_cnt_r;
	logic [31:0] addr_r;
	logic [7:0] bank_r;
	logic [7:0] bank_nv_r;
	logic bank_nv_sel_r;
	logic [15:0] asp_r;
	logic [31:0] boot_r;
	logic boot_seen_r;
	logic prot_err_r;
	logic p_err_r;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire [7:0] in_byte = {in_sr_r[6:0], mosi_s_r[1]};
	wire byte_done = sck_rise & (bit_cnt_r == 3'h7);
	wire opc_done = byte_done & (state_r == flash_link_pkg::ST_OPCODE);
	wire [31:0] acc_nxt = {acc_r[23:0], in_byte};

	wire is_rd_bank = (in_byte == `OPC_RD_BANK_A) | (in_byte == `OPC_RD_BANK_B);
	wire is_wr_bank_v = (in_byte == `OPC_WR_BANK_V_A) | (in_byte == `OPC_WR_BANK_V_B);
	wire is_wr_bank_nv = in_byte == `OPC_WR_BANK_NV;
	wire is_enter = in_byte == `OPC_ENTER_WIDE;
	wire is_exit = in_byte == `OPC_EXIT_WIDE;
	wire is_rd_prot = in_byte == `OPC_RD_PROT;
	wire is_pg_prot = in_byte == `OPC_PG_PROT;
	wire is_rd_ext = in_byte == `OPC_RD_EXT;
	wire is_rd_boot = in_byte == `OPC_RD_BOOT;
	wire is_wr_boot = in_byte == `OPC_WR_BOOT;
	wire is_read = in_byte == `OPC_ARRAY_READ;
	wire is_clr = in_byte == `OPC_CLR_ERR;
	wire is_swrst = in_byte == `OPC_SW_RESET;
	wire is_reg_rd = is_rd_bank | is_rd_prot | is_rd_ext | is_rd_boot;

	// Flags never gate decode, so a pending error blocks nothing
	assign opc_state = is_reg_rd ? flash_link_pkg::ST_REG_OUT :
		(is_wr_bank_v | is_wr_bank_nv) ? flash_link_pkg::ST_BANK_WR :
		is_pg_prot ? flash_link_pkg::ST_PROT_WR :
		is_wr_boot ? flash_link_pkg::ST_BOOT_WR :
		is_read ? flash_link_pkg::ST_ADDR : flash_link_pkg::ST_IGNORE;

	wire wide = bank_r[`BANK_WIDE_BIT];
	wire [2:0] addr_bytes = wide ? 3'h4 : 3'h3;
	wire addr_last = byte_done & (state_r == flash_link_pkg::ST_ADDR) & (byte_cnt_r == addr_bytes);
	// Three-byte addresses take the segment bit; wide mode uses the full field
	wire [31:0] addr_full = wide ? acc_nxt :
		{7'h00, bank_r[`BANK_SEG_BIT], acc_nxt[23:0]};

	wire [3:0] dly_cycles = boot_delay(boot_r[4:1], quad_enable_bit_in);
	wire boot_go = cs_fall & boot_r[0] & ~boot_seen_r;
	wire dummy_end = sck_rise & (state_r == flash_link_pkg::ST_DUMMY) &
		(dly_cnt_r == dly_cycles - 4'h1);
	wire stream_load = sck_fall & (state_r == flash_link_pkg::ST_STREAM) & (out_cnt_r == 3'h0);

	wire bank_wr = byte_done & (state_r == flash_link_pkg::ST_BANK_WR);
	// Reserved bank bits are dropped from the written byte
	wire [7:0] bank_wdata = {in_byte[`BANK_WIDE_BIT], 6'h00, in_byte[`BANK_SEG_BIT]};
	wire boot_wr = byte_done & (state_r == flash_link_pkg::ST_BOOT_WR) & (byte_cnt_r == 3'h4);

	// Protection register programming clears bits only
	wire asp_pg = byte_done & (state_r == flash_link_pkg::ST_PROT_WR) & (byte_cnt_r == 3'h2);
	wire [15:0] asp_data = acc_nxt[15:0];
	wire mode_locked = asp_r[2:1] != 2'h3;
	wire both_zero = asp_data[2:1] == 2'h0;
	wire relock = mode_locked & (|(~asp_data[2:1] & asp_r[2:1]));
	wire asp_err = both_zero | relock;
	wire tb_nxt = freeze_lock_in ? asp_r[`ASP_PARAM_LOC_BIT] :
		(asp_r[`ASP_PARAM_LOC_BIT] & asp_data[`ASP_PARAM_LOC_BIT]);
	wire [15:0] asp_nxt = {tb_nxt, asp_r[14:3], asp_r[2:1] & asp_data[2:1], asp_r[0]};

	wire [7:0] ext_status = `EXT_FIXED | {5'h00, p_err_r, prot_err_r, 1'b0};
	wire [31:0] reg_word = is_rd_bank ? {bank_r, 24'h000000} :
		is_rd_prot ? {asp_r, 16'h0000} :
		is_rd_ext ? {ext_status, 24'h000000} : boot_r;

	wire err_set = asp_pg & asp_err;
	wire err_clr = opc_done & (is_clr | is_swrst);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		if (cs_fall) begin
			state_nxt = boot_go ? flash_link_pkg::ST_DUMMY : flash_link_pkg::ST_OPCODE;
		end else if (!sel) begin
			state_nxt = flash_link_pkg::ST_IDLE;
		end else if (dummy_end || addr_last) begin
			state_nxt = flash_link_pkg::ST_STREAM;
		end else if (byte_done) begin
			case (state_r)
				flash_link_pkg::ST_OPCODE: state_nxt = opc_state;
				flash_link_pkg::ST_BANK_WR: state_nxt = flash_link_pkg::ST_IGNORE;
				flash_link_pkg::ST_PROT_WR: state_nxt = asp_pg ? flash_link_pkg::ST_IGNORE : state_r;
				flash_link_pkg::ST_BOOT_WR: state_nxt = boot_wr ? flash_link_pkg::ST_IGNORE : state_r;
				default: state_nxt = state_r;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= flash_link_pkg::ST_IDLE;
			boot_seen_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			// Software reset re-arms auto-boot; the boot word itself survives it
			boot_seen_r <= (boot_seen_r | cs_fall) & ~(opc_done & is_swrst);
		end
	end

	// ----------------------------------------
	// Inbound shifting
	// ----------------------------------------
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			in_sr_r <= 8'h00;
			bit_cnt_r <= 3'h0;
			byte_cnt_r <= 3'h0;
			acc_r <= 32'h00000000;
			dly_cnt_r <= 4'h0;
		end else if (cs_fall) begin
			bit_cnt_r <= 3'h0;
			byte_cnt_r <= 3'h0;
			acc_r <= 32'h00000000;
			dly_cnt_r <= 4'h0;
		end else if (sck_rise) begin
			in_sr_r <= in_byte;
			bit_cnt_r <= bit_cnt_r + 3'h1;
			dly_cnt_r <= dly_cnt_r + 4'h1;
			if (byte_done) begin
				acc_r <= acc_nxt;
				// Saturate so long streams do not wrap back onto write slots
				byte_cnt_r <= (byte_cnt_r == 3'h7) ? byte_cnt_r : byte_cnt_r + 3'h1;
			end
		end
	end

	// ----------------------------------------
	// Outbound shifting and array address
	// ----------------------------------------
	// Data leaves on falling edges; hold keeps the first bit of a register
	// word in place across the falling edge that follows the opcode.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			out_sr_r <= 32'h00000000;
			hold_r <= 1'b0;
			out_cnt_r <= 3'h0;
		end else if (cs_fall) begin
			out_sr_r <= 32'h00000000;
			hold_r <= 1'b0;
			out_cnt_r <= 3'h0;
		end else if (opc_done && is_reg_rd) begin
			out_sr_r <= reg_word;
			hold_r <= 1'b1;
		end else if (sck_fall) begin
			hold_r <= 1'b0;
			if (stream_load) begin
				out_sr_r <= {array_data_in, 24'h000000};
			end else if (!hold_r) begin
				out_sr_r <= {out_sr_r[30:0], 1'b0};
			end
			if (state_r == flash_link_pkg::ST_STREAM) begin
				out_cnt_r <= out_cnt_r + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			addr_r <= 32'h00000000;
		end else if (boot_go) begin
			addr_r <= {boot_r[31:5], 5'h00};
		end else if (addr_last) begin
			addr_r <= addr_full;
		end else if (stream_load) begin
			addr_r <= addr_r + 32'h00000001;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bank_r <= `BANK_RESET;
			bank_nv_r <= `BANK_RESET;
			bank_nv_sel_r <= 1'b0;
		end else if (opc_done) begin
			bank_nv_sel_r <= is_wr_bank_nv;
			if (is_enter) begin
				bank_r[`BANK_WIDE_BIT] <= 1'b1;
			end else if (is_exit) begin
				bank_r[`BANK_WIDE_BIT] <= 1'b0;
			end else if (is_swrst) begin
				bank_r <= bank_nv_r;
			end
		end else if (bank_wr) begin
			bank_r <= bank_wdata;
			if (bank_nv_sel_r) begin
				bank_nv_r <= bank_wdata;
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			asp_r <= `ASP_RESET;
			boot_r <= `BOOT_RESET;
		end else begin
			if (asp_pg && !asp_err) begin
				asp_r <= asp_nxt;
			end
			if (boot_wr) begin
				boot_r <= acc_nxt;
			end
		end
	end

	// ----------------------------------------
	// Sticky error flags
	// ----------------------------------------
	// A new error in the clearing cycle wins over the clear
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prot_err_r <= 1'b0;
			p_err_r <= 1'b0;
		end else begin
			prot_err_r <= prot_fail_in | err_set | (prot_err_r & ~err_clr);
			p_err_r <= prog_fail_in | err_set | (p_err_r & ~err_clr);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.miso = out_sr_r[31];
	assign link.miso_oe = sel & ((state_r == flash_link_pkg::ST_REG_OUT) |
		(state_r == flash_link_pkg::ST_STREAM));
	assign array_addr_out = addr_r;
	assign array_addr_valid_out = state_r == flash_link_pkg::ST_STREAM;
	assign four_byte_addr_sel_out = bank_r[`BANK_WIDE_BIT];
	assign protection_error_flag_out = prot_err_r;
	assign program_error_flag_out = p_err_r;
	assign advanced_protection_config_out = asp_r;

endmodule : flash_cfg_device

// ==== design/flash_cfg_host.sv ====
// Host end: runs one serial transaction per software order.
// Assumes a plain register port on the core clock and a device that answers
// in mode 0 within half a link clock.
`timescale 1ns/1ps
`include "flash_link_cfg.svh"

module flash_cfg_host (
	input wire logic core_clk_in,
	input wire logic rst_in,
	spi_link_if.host link,
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	flash_link_pkg::host_state_t state_r;
	logic [39:0] sh_r;
	logic [6:0] bits_left_r;
	logic [2:0] div_r;
	logic sck_r;
	logic cs_n_r;
	logic [31:0] tx_r;
	logic [31:0] rx_r;
	logic [13:0] ctrl_r;
	logic wide_r;
	logic [1:0] miso_s_r;
	logic [31:0] rdata_r;

	wire busy = state_r != flash_link_pkg::H_IDLE;
	wire start = reg_wr_in & (reg_addr_in == `HREG_CTRL) & ~busy;
	wire [7:0] opcode = reg_wdata_in[7:0];
	// Bytes on the wire: opcode, tx bytes, rx bytes
	wire [6:0] total_bits = {4'h1 + {1'b0, reg_wdata_in[10:8]} + {1'b0, reg_wdata_in[13:11]},
		3'h0};
	wire fall_ph = div_r == `SCK_FALL_PH;

	wire [31:0] read_mux = (reg_addr_in == `HREG_CTRL) ? {18'h00000, ctrl_r} :
		(reg_addr_in == `HREG_TX) ? tx_r :
		(reg_addr_in == `HREG_RX) ? rx_r :
		(reg_addr_in == `HREG_STAT) ? {30'h00000000, wide_r, busy} : 32'h00000000;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			miso_s_r <= 2'h0;
			rdata_r <= 32'h00000000;
		end else begin
			miso_s_r <= {miso_s_r[0], link.miso};
			rdata_r <= reg_rd_in ? read_mux : 32'h00000000;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_r <= 32'h00000000;
			ctrl_r <= 14'h0000;
			wide_r <= 1'b0;
		end else if (start) begin
			ctrl_r <= reg_wdata_in[13:0];
			// Software must give four address bytes while wide mode is on
			if (opcode == `OPC_ENTER_WIDE) begin
				wide_r <= 1'b1;
			end else if (opcode == `OPC_EXIT_WIDE) begin
				wide_r <= 1'b0;
			end
		end else if (reg_wr_in && reg_addr_in == `HREG_TX && !busy) begin
			tx_r <= reg_wdata_in;
		end
	end

	// ----------------------------------------
	// Link engine
	// ----------------------------------------
	// Sck period is eight core clocks; miso is sampled late in the high
	// phase because the device reacts only after its own synchronisers.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= flash_link_pkg::H_IDLE;
			sh_r <= 40'h0000000000;
			bits_left_r <= 7'h00;
			div_r <= 3'h0;
			sck_r <= 1'b0;
			cs_n_r <= 1'b1;
			rx_r <= 32'h00000000;
		end else begin
			div_r <= div_r + 3'h1;
			case (state_r)
				flash_link_pkg::H_IDLE: begin
					div_r <= 3'h0;
					if (start) begin
						sh_r <= {opcode, tx_r};
						bits_left_r <= total_bits;
						cs_n_r <= 1'b0;
						state_r <= flash_link_pkg::H_SHIFT;
					end
				end
				flash_link_pkg::H_SHIFT: begin
					if (div_r == `SCK_RISE_PH) begin
						sck_r <= 1'b1;
					end else if (fall_ph) begin
						sck_r <= 1'b0;
						rx_r <= {rx_r[30:0], miso_s_r[1]};
						sh_r <= {sh_r[38:0], 1'b0};
						bits_left_r <= bits_left_r - 7'h01;
						if (bits_left_r == 7'h01) begin
							state_r <= flash_link_pkg::H_GAP;
						end
					end
				end
				flash_link_pkg::H_GAP: begin
					if (div_r == `SCK_RISE_PH) begin
						cs_n_r <= 1'b1;
					end else if (fall_ph) begin
						state_r <= flash_link_pkg::H_IDLE;
					end
				end
				default: state_r <= flash_link_pkg::H_IDLE;
			endcase
		end
	end

	assign link.sck = sck_r;
	assign link.cs_n = cs_n_r;
	assign link.mosi = sh_r[39];
	assign reg_rdata_out = rdata_r;

endmodule : flash_cfg_host

// ==== bench/flash_cfg_props.sv ====
// Checker for the serial link between the host end and the device end.
// Assumes both ends run on one core clock and the bench hands in the wires.
`timescale 1ns/1ps
`include "flash_link_cfg.svh"
module flash_cfg_props (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	// --------
	// Opcode capture
	// --------
	logic sck_r;
	logic [3:0] cnt_r;
	logic [6:0] sr_r;
	logic done_r;
	logic [7:0] opc_r;
	wire rise = sck & ~sck_r;
	wire last = rise & ~cs_n & (cnt_r == 4'h7);
	// Counter saturates so data bytes are never taken for opcodes
	wire [3:0] cnt_nxt = cs_n ? 4'h0 : (rise && cnt_r != 4'h8) ? cnt_r + 4'h1 : cnt_r;
	wire rd_bank = done_r && (opc_r == `OPC_RD_BANK_A || opc_r == `OPC_RD_BANK_B);
	wire wr_bank = done_r && (opc_r == `OPC_WR_BANK_V_A || opc_r == `OPC_WR_BANK_V_B
		|| opc_r == `OPC_WR_BANK_NV);
	wire wide_cmd = done_r && (opc_r == `OPC_ENTER_WIDE || opc_r == `OPC_EXIT_WIDE);
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sck_r <= 1'b0;
			cnt_r <= 4'h0;
			sr_r <= 7'h0;
			done_r <= 1'b0;
			opc_r <= 8'h0;
		end else begin
			sck_r <= sck;
			cnt_r <= cnt_nxt;
			sr_r <= rise ? {sr_r[5:0], mosi} : sr_r;
			done_r <= last;
			opc_r <= last ? {sr_r, mosi} : opc_r;
		end
	end
	// --------
	// Properties
	// --------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	AST_RD_BANK_DRIVES: assert property (rd_bank |-> ##[0:16] miso_oe)
		else $error("bank read not answered");
	AST_RD_PROT_DRIVES: assert property (
		done_r && opc_r == `OPC_RD_PROT |-> ##[0:16] miso_oe)
		else $error("protection read not answered");
	AST_RD_EXT_DRIVES: assert property (
		done_r && opc_r == `OPC_RD_EXT |-> ##[0:16] miso_oe)
		else $error("status read not answered");
	AST_WR_BANK_QUIET: assert property (wr_bank |-> !miso_oe [*8])
		else $error("device drove during bank write");
	AST_WIDE_QUIET: assert property (wide_cmd |-> !miso_oe [*8])
		else $error("device drove during mode command");
	AST_NO_EARLY_DRIVE: assert property ($fell(cs_n) |-> !miso_oe [*8])
		else $error("device drove before opcode");
	AST_RELEASE: assert property ($rose(cs_n) |-> ##[0:6] !miso_oe)
		else $error("device kept driving after deselect");
	AST_MOSI_HOLD: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("mosi moved while clock high");
	AST_IDLE_SCK: assert property (cs_n |-> !sck)
		else $error("link clock high while deselected");
	cover property (rd_bank);
	cover property (done_r && opc_r == `OPC_PG_PROT);
	cover property (wide_cmd);
endmodule : flash_cfg_props

// ==== bench/flash_boot_addr_protect_regs_bench.sv ====
// Bench joining host and device ends over one link, driven by register calls.
// Assumes package, interface, design files and checker are compiled first.
`timescale 1ns/1ps
`include "flash_link_cfg.svh"
module flash_boot_addr_protect_regs_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] ra = 4'h0;
	logic [31:0] wd = 32'h0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic frz = 1'b0;
	logic pgf = 1'b0;
	logic ptf = 1'b0;
	logic qe = 1'b0;
	logic [31:0] rdat;
	logic [31:0] aad;
	logic aval;
	logic wide;
	logic pte;
	logic pge;
	logic [15:0] apc;
	logic [31:0] cap = 32'h0;
	logic seen = 1'b0;
	logic [31:0] v;
	int miscompares = 0;
	int num_checks = 0;
	spi_link_if link_if();
	always #10 clk = ~clk;
	flash_cfg_device flash_cfg_device_inst (.core_clk_in(clk), .rst_in(rst), .link(link_if),
		.quad_enable_bit_in(qe), .freeze_lock_in(frz), .prog_fail_in(pgf),
		.prot_fail_in(ptf), .array_data_in(8'ha5), .array_addr_out(aad),
		.array_addr_valid_out(aval), .four_byte_addr_sel_out(wide),
		.protection_error_flag_out(pte), .program_error_flag_out(pge),
		.advanced_protection_config_out(apc));
	flash_cfg_host flash_cfg_host_inst (.core_clk_in(clk), .rst_in(rst), .link(link_if),
		.reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
		.reg_rdata_out(rdat));
	flash_cfg_props flash_cfg_props_inst (.core_clk_in(clk), .rst_in(rst), .sck(link_if.sck),
		.cs_n(link_if.cs_n), .mosi(link_if.mosi), .miso(link_if.miso),
		.miso_oe(link_if.miso_oe));
	// First address seen on the array side of each read
	always @(posedge clk) begin
		if (aval && !seen) begin
			cap <= aad;
			seen <= 1'b1;
		end
	end
	// --------
	// Tasks
	// --------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		ra <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		d = rdat;
	endtask : rd
	// Runs one frame; the received bytes land masked in v
	task automatic cmd(input logic [7:0] op, input logic [2:0] nt, input logic [2:0] nr,
		input logic [31:0] tx);
		int n;
		n = 0;
		wr(`HREG_TX, tx);
		wr(`HREG_CTRL, {18'h0, nr, nt, op});
		v = 32'h1;
		while (v[0] !== 1'b0 && n < 3000) begin
			rd(`HREG_STAT, v);
			n++;
		end
		if (v[0] !== 1'b0) miscompares++;
		rd(`HREG_RX, v);
		v = v & ~(32'hffffffff << (8 * nr));
	endtask : cmd
	task automatic flags(input logic [1:0] e);
		chk({30'h0, pte, pge}, {30'h0, e});
	endtask : flags
	task automatic pulse(input logic pg);
		@(posedge clk);
		pgf <= pg;
		ptf <= !pg;
		@(posedge clk);
		pgf <= 1'b0;
		ptf <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : pulse
	task automatic conclude();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	// --------
	// Tests
	// --------
	initial begin
		repeat (90000) @(posedge clk);
		miscompares++;
		conclude();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		cmd(`OPC_RD_BANK_A, 3'h0, 3'h1, 32'h0);
		chk(v, 32'h0);
		chk({31'h0, wide}, 32'h0);
		cmd(`OPC_RD_PROT, 3'h0, 3'h2, 32'h0);
		chk(v, 32'hffff);
		chk({16'h0, apc}, 32'hffff);
		cmd(`OPC_RD_BOOT, 3'h0, 3'h4, 32'h0);
		chk(v, 32'h0);
		cmd(`OPC_RD_EXT, 3'h0, 3'h1, 32'h0);
		chk(v, 32'hf0);
		$display("test reset values done");
		cmd(`OPC_WR_BANK_V_A, 3'h1, 3'h0, 32'hff000000);
		cmd(`OPC_RD_BANK_B, 3'h0, 3'h1, 32'h0);
		chk(v, 32'h81);
		chk({31'h0, wide}, 32'h1);
		cmd(`OPC_WR_BANK_V_B, 3'h1, 3'h0, 32'h0);
		cmd(`OPC_RD_BANK_A, 3'h0, 3'h1, 32'h0);
		chk(v, 32'h0);
		cmd(`OPC_ENTER_WIDE, 3'h0, 3'h0, 32'h0);
		chk({31'h0, wide}, 32'h1);
		cmd(`OPC_EXIT_WIDE, 3'h0, 3'h0, 32'h0);
		chk({31'h0, wide}, 32'h0);
		cmd(`OPC_WR_BANK_NV, 3'h1, 3'h0, 32'h01000000);
		cmd(`OPC_RD_BANK_A, 3'h0, 3'h1, 32'h0);
		chk(v, 32'h1);
		$display("test bank done");
		seen = 1'b0;
		cmd(`OPC_ARRAY_READ, 3'h3, 3'h1, 32'h12345600);
		chk(v, 32'ha5);
		chk(cap, 32'h01123456);
		cmd(`OPC_ENTER_WIDE, 3'h0, 3'h0, 32'h0);
		seen = 1'b0;
		cmd(`OPC_ARRAY_READ, 3'h4, 3'h1, 32'h00abcdef);
		chk(cap, 32'h00abcdef);
		cmd(`OPC_EXIT_WIDE, 3'h0, 3'h0, 32'h0);
		$display("test array address done");
		cmd(`OPC_PG_PROT, 3'h2, 3'h0, 32'hfff90000);
		flags(2'h3);
		cmd(`OPC_RD_PROT, 3'h0, 3'h2, 32'h0);
		chk(v, 32'hffff);
		cmd(`OPC_WR_BANK_V_A, 3'h1, 3'h0, 32'h0);
		cmd(`OPC_RD_BANK_A, 3'h0, 3'h1, 32'h0);
		chk(v, 32'h0);
		flags(2'h3);
		cmd(`OPC_RD_EXT, 3'h0, 3'h1, 32'h0);
		chk(v, 32'hf6);
		cmd(`OPC_CLR_ERR, 3'h0, 3'h0, 32'h0);
		flags(2'h0);
		pulse(1'b1);
		flags(2'h1);
		pulse(1'b0);
		flags(2'h3);
		cmd(`OPC_SW_RESET, 3'h0, 3'h0, 32'h0);
		flags(2'h0);
		cmd(`OPC_RD_BANK_A, 3'h0, 3'h1, 32'h0);
		chk(v, 32'h1);
		$display("test error flags done");
		cmd(`OPC_WR_BOOT, 3'h4, 3'h0, 32'h12345ab3);
		cmd(`OPC_RD_BOOT, 3'h0, 3'h4, 32'h0);
		chk(v, 32'h12345ab3);
		// Auto-boot armed by software reset: default delay, 8 then 6 with quad
		cmd(`OPC_WR_BOOT, 3'h4, 3'h0, 32'h12345aa1);
		cmd(`OPC_SW_RESET, 3'h0, 3'h0, 32'h0);
		seen = 1'b0;
		cmd(8'h00, 3'h0, 3'h1, 32'h0);
		chk(v, 32'ha5);
		chk(cap, 32'h12345aa0);
		@(posedge clk);
		qe <= 1'b1;
		cmd(`OPC_SW_RESET, 3'h0, 3'h0, 32'h0);
		seen = 1'b0;
		cmd(8'h00, 3'h0, 3'h1, 32'h0);
		chk(v, 32'h96);
		chk(cap, 32'h12345aa0);
		$display("test boot done");
		@(posedge clk);
		frz <= 1'b1;
		cmd(`OPC_PG_PROT, 3'h2, 3'h0, 32'h7fff0000);
		cmd(`OPC_RD_PROT, 3'h0, 3'h2, 32'h0);
		chk(v, 32'hffff);
		@(posedge clk);
		frz <= 1'b0;
		cmd(`OPC_PG_PROT, 3'h2, 3'h0, 32'h7ffd0000);
		chk({16'h0, apc}, 32'h7ffd);
		cmd(`OPC_PG_PROT, 3'h2, 3'h0, 32'hffff0000);
		cmd(`OPC_RD_PROT, 3'h0, 3'h2, 32'h0);
		chk(v, 32'h7ffd);
		$display("test protection done");
		pulse(1'b1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		flags(2'h0);
		cmd(`OPC_RD_BANK_A, 3'h0, 3'h1, 32'h0);
		chk(v, 32'h0);
		$display("test hardware reset done");
		conclude();
	end
endmodule : flash_boot_addr_protect_regs_bench
